/* File: pkg/tmd_regs.vh */
// constants for the tuner mcu instruction decoder
`ifndef TMD_REGS_VH
`define TMD_REGS_VH
`define TMD_CTRL_OFF   12'h000
`define TMD_STAT_OFF   12'h004
`define TMD_CTRL_RST   1'b0
`define TMD_PC_RST     13'h0000
`define TMD_BANK_RST   4'h0
`define TMD_STAT_PC_LO 0
`define TMD_STAT_BANK  16
`define TMD_STAT_CARRY 20
`define TMD_STAT_HALT  21
`define TMD_STAT_OSTP  22
`define TMD_STAT_SP    24
`define TMD_PK_COUNTER_CTRL_WORD1   4'h1
`define TMD_PK_COUNTER_CTRL_WORD2   4'h2
`define TMD_PK_BEEP    4'h3
`define TMD_PK_DZC     4'h4
`define TMD_PK_TMS     4'h5
`define TMD_PK_IOS     4'h6
`define TMD_PK_IREG    4'h7
`define TMD_PK_PLL     4'h8
`define TMD_PK_PORT    4'h9
`define TMD_PK_SEG_DIRECT_A    4'hA
`define TMD_PK_SEG_DIRECT_B    4'hB
`define TMD_PK_HALT    4'hC
`define TMD_PK_SIO     4'hD
`define TMD_PK_DAC     4'hE
`endif

/* File: logic/tmd_alu.v */
// four-bit adder and subtractor with carry or borrow
`timescale 1ns/1ps
module tmd_alu (
   input  wire [3:0] a,
   input  wire [3:0] b,
   input  wire       ci,
   input  wire       sub,
   output wire [3:0] y,
   output wire       co
);
   wire [4:0] sum;
   wire [4:0] dif;
   assign sum = {1'b0, a} + {1'b0, b} + {4'h0, ci};
   assign dif = {1'b0, a} - {1'b0, b} - {4'h0, ci};
   // co is carry out for add, borrow out for subtract
   assign y  = sub ? dif[3:0] : sum[3:0];
   assign co = sub ? dif[4] : sum[4];
endmodule

/* File: logic/tmd_core.v */
// instruction decoder and executer with apb control port
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "tmd_regs.vh"
module tmd_core (
   input  wire        pclk,
   input  wire        presetn,
   input  wire [11:0] paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg  [12:0] pm_addr,
   input  wire [15:0] pm_data,
   input  wire [63:0] port_in,
   input  wire [3:0]  unlock_in,
   input  wire        hold_in,
   input  wire        wake_in,
   output reg         per_we,
   output reg  [3:0]  per_kind,
   output reg  [3:0]  per_addr,
   output reg  [7:0]  per_data,
   output reg         halted,
   output reg         osc_stop
);
   reg [3:0]  mem [0:511];
   reg [17:0] stk [0:7];
   reg [3:0]  stat_r [0:3];
   reg [3:0]  plat_r [0:15];
   reg [3:0]  ireg_r [0:15];
   reg [12:0] pc_r;
   reg [3:0]  bank_r;
   reg [2:0]  sp_r;
   reg        carry_r;
   reg        skip_r;
   reg        run_r;
   reg [69:0] s1_r;
   reg [69:0] s2_r;
   reg [69:0] s3_r;
   reg [69:0] sv_r;
   integer    i;

   function [3:0] nib;
      input [63:0] v;
      input [3:0]  k;
      begin
         nib = v[k*4 +: 4];
      end
   endfunction

   // logic array: nibble to seven-segment pattern
   function [7:0] seg_of;
      input [3:0] d;
      begin
         case (d)
            4'h0: seg_of = 8'h3F;
            4'h1: seg_of = 8'h06;
            4'h2: seg_of = 8'h5B;
            4'h3: seg_of = 8'h4F;
            4'h4: seg_of = 8'h66;
            4'h5: seg_of = 8'h6D;
            4'h6: seg_of = 8'h7D;
            4'h7: seg_of = 8'h07;
            4'h8: seg_of = 8'h7F;
            4'h9: seg_of = 8'h6F;
            4'hA: seg_of = 8'h77;
            4'hB: seg_of = 8'h7C;
            4'hC: seg_of = 8'h39;
            4'hD: seg_of = 8'h5E;
            4'hE: seg_of = 8'h79;
            default: seg_of = 8'h71;
         endcase
      end
   endfunction

   wire [63:0] port_s = sv_r[63:0];
   wire [3:0]  unl_s  = sv_r[67:64];
   wire        hold_s = sv_r[68];
   wire        wake_s = sv_r[69];

   wire [15:0] ins = pm_data;
   wire [1:0]  dh  = ins[9:8];
   wire [3:0]  dl  = ins[7:4];
   wire [3:0]  lo  = ins[3:0];
   wire [8:0]  m_a = {bank_r[2:0], dh, dl};
   wire [8:0]  r_a = {bank_r[2:0], 2'b00, lo};
   wire [3:0]  mv  = mem[m_a];
   wire [3:0]  rv  = mem[r_a];
   wire [8:0]  i_a = {bank_r[2:0], dh, rv};
   wire [8:0]  s_a = {bank_r[2:0], dh, lo};
   wire [3:0]  iv  = mem[i_a];
   wire [3:0]  sv  = mem[s_a];
   wire [17:0] top = stk[sp_r - 3'd1];
   wire        active = run_r & ~halted & ~osc_stop;
   wire        do_ex  = active & ~skip_r;
   wire [12:0] pc_inc = pc_r + 13'd1;

   reg  [3:0]  al_a;
   reg  [3:0]  al_b;
   reg         al_ci;
   reg         al_sub;
   wire [3:0]  al_y;
   wire        al_co;

   tmd_alu u_alu (
      .a   (al_a),
      .b   (al_b),
      .ci  (al_ci),
      .sub (al_sub),
      .y   (al_y),
      .co  (al_co)
   );

   reg        m_we;
   reg [8:0]  m_wa;
   reg [3:0]  m_wd;
   reg        c_nxt;
   reg        skip_nxt;
   reg [12:0] pc_nxt;
   reg [3:0]  bank_nxt;
   reg        push;
   reg        pop;
   reg        pe_nxt;
   reg [3:0]  pk_nxt;
   reg [3:0]  pa_nxt;
   reg [7:0]  pd_nxt;
   reg        st_we;
   reg [1:0]  st_idx;
   reg [3:0]  st_val;
   reg        pl_we;
   reg [3:0]  pl_val;
   reg        ir_we;
   reg        halt_nxt;
   reg        ostp_nxt;

   always @* begin
      al_a = rv;
      al_b = mv;
      al_ci = 1'b0;
      al_sub = 1'b0;
      m_we = 1'b0;
      m_wa = m_a;
      m_wd = al_y;
      c_nxt = carry_r;
      skip_nxt = 1'b0;
      pc_nxt = pc_inc;
      bank_nxt = bank_r;
      push = 1'b0;
      pop = 1'b0;
      pe_nxt = 1'b0;
      pk_nxt = 4'h0;
      pa_nxt = lo;
      pd_nxt = {4'h0, mv};
      st_we = 1'b0;
      st_idx = ins[5:4];
      st_val = stat_r[ins[5:4]];
      pl_we = 1'b0;
      pl_val = plat_r[dl];
      ir_we = 1'b0;
      halt_nxt = 1'b0;
      ostp_nxt = 1'b0;
      casez (ins[15:10])
         6'b0100??, 6'b0110??: begin
            al_sub = ins[13];
            al_ci = ins[11] & carry_r;
            m_we = 1'b1;
            m_wa = r_a;
            c_nxt = al_co;
            skip_nxt = ins[10] & al_co;
         end
         6'b0101??, 6'b0111??: begin
            al_a = mv;
            al_b = lo;
            al_sub = ins[13];
            al_ci = ins[11] & carry_r;
            m_we = 1'b1;
            c_nxt = al_co;
            skip_nxt = ins[10] & al_co;
         end
         6'b000100, 6'b000101, 6'b000110, 6'b000111,
         6'b000001, 6'b000011: begin
            al_sub = 1'b1;
            if (ins[12] == 1'b0 || ins[10]) begin
               al_a = mv;
               al_b = lo;
            end
            if (ins[12])
               skip_nxt = ins[11] ? ~al_co : (al_y == 4'h0);
            else
               skip_nxt = ins[11] ? al_co : (al_y != 4'h0);
         end
         6'b001000: begin m_we = 1'b1; m_wa = r_a; m_wd = rv & mv; end
         6'b001001: begin m_we = 1'b1; m_wd = mv & lo; end
         6'b001010: begin m_we = 1'b1; m_wa = r_a; m_wd = rv | mv; end
         6'b001011: begin m_we = 1'b1; m_wd = mv | lo; end
         6'b001100: begin m_we = 1'b1; m_wa = r_a; m_wd = rv ^ mv; end
         6'b001101: begin m_we = 1'b1; m_wd = mv ^ lo; end
         6'b001110: begin m_we = 1'b1; m_wd = ireg_r[lo]; end
         6'b001111: begin ir_we = 1'b1; pe_nxt = 1'b1; pk_nxt = `TMD_PK_IREG; end
         6'b110100: begin m_we = 1'b1; m_wa = r_a; m_wd = mv; end
         6'b110101: begin m_we = 1'b1; m_wd = rv; end
         6'b110110: begin m_we = 1'b1; m_wa = i_a; m_wd = mv; end
         6'b110111: begin m_we = 1'b1; m_wd = iv; end
         6'b111000: begin m_we = 1'b1; m_wd = sv; end
         6'b111001: begin m_we = 1'b1; m_wd = lo; end
         6'b111010: begin m_we = 1'b1; m_wd = nib(port_s, lo); end
         6'b111011: begin
            pl_we = 1'b1;
            pl_val = mv;
            pe_nxt = 1'b1;
            pk_nxt = `TMD_PK_PORT;
            pa_nxt = lo;
         end
         6'b111100: skip_nxt = ((mv & lo) == lo);
         6'b111101: skip_nxt = ((mv & lo) == 4'h0);
         6'b111110: begin pe_nxt = 1'b1; pk_nxt = `TMD_PK_PLL; end
         6'b1100??: begin
            pe_nxt = 1'b1;
            pk_nxt = ins[10] ? `TMD_PK_SEG_DIRECT_B : `TMD_PK_SEG_DIRECT_A;
            pd_nxt = ins[11] ? seg_of(mv) : {4'h0, mv};
         end
         6'b100???: pc_nxt = ins[12:0];
         6'b101???: begin
            pc_nxt = ins[12:0];
            push = 1'b1;
         end
         6'b111111: begin
            case (ins[9:8])
               2'b00: skip_nxt = ((nib(port_s, dl) & lo) == lo);
               2'b01: skip_nxt = ((nib(port_s, dl) & lo) == 4'h0);
               2'b10: begin
                  pe_nxt = 1'b1;
                  pk_nxt = `TMD_PK_IOS;
                  pa_nxt = dl;
                  pd_nxt = {4'h0, lo};
               end
               default: begin
                  casez (ins[7:4])
                     4'b110?: begin
                        pop = 1'b1;
                        pc_nxt = ins[4] ? top[12:0] + 13'd1 : top[12:0];
                        bank_nxt = top[16:13];
                     end
                     4'b00?1: begin
                        st_we = 1'b1;
                        st_idx = {1'b0, ins[4]};
                        st_val = ins[5] ? (stat_r[st_idx] & ~lo) : (stat_r[st_idx] | lo);
                     end
                     4'b01??: skip_nxt = ((stat_r[ins[5:4]] & lo) == lo);
                     4'b10??: skip_nxt = ((stat_r[ins[5:4]] & lo) == 4'h0);
                     default: skip_nxt = 1'b0;
                  endcase
               end
            endcase
         end
         6'b000000: begin
            case (ins[9:8])
               2'b01: begin
                  pe_nxt = 1'b1;
                  pk_nxt = `TMD_PK_SIO;
                  pd_nxt = {dl, lo};
               end
               2'b10, 2'b11: begin
                  pl_we = 1'b1;
                  pl_val = ins[8] ? (plat_r[dl] & ~lo) : (plat_r[dl] | lo);
                  pe_nxt = 1'b1;
                  pk_nxt = `TMD_PK_PORT;
                  pa_nxt = dl;
                  pd_nxt = {4'h0, pl_val};
               end
               default: begin
                  pd_nxt = {4'h0, lo};
                  case (dl)
                     4'h1: begin pe_nxt = 1'b1; pk_nxt = `TMD_PK_COUNTER_CTRL_WORD1; end
                     4'h2: begin pe_nxt = 1'b1; pk_nxt = `TMD_PK_COUNTER_CTRL_WORD2; end
                     4'h3: begin pe_nxt = 1'b1; pk_nxt = `TMD_PK_DAC; end
                     4'h4: begin
                        pe_nxt = 1'b1;
                        pk_nxt = `TMD_PK_HALT;
                        halt_nxt = 1'b1;
                     end
                     4'h5: ostp_nxt = ~hold_s;
                     4'h6: begin pe_nxt = 1'b1; pk_nxt = `TMD_PK_BEEP; end
                     4'h7: bank_nxt = lo;
                     4'h8, 4'h9, 4'hA: begin
                        pop = 1'b1;
                        pc_nxt = (dl == 4'hA) ? top[12:0] + 13'd1 : top[12:0];
                        if (dl == 4'h9) begin
                           bank_nxt = top[16:13];
                           c_nxt = top[17];
                        end
                     end
                     4'hB: begin pe_nxt = 1'b1; pk_nxt = `TMD_PK_DZC; end
                     4'hC: begin pe_nxt = 1'b1; pk_nxt = `TMD_PK_TMS; end
                     4'hD: skip_nxt = ((unl_s & lo) == 4'h0);
                     4'hE: begin
                        m_we = 1'b1;
                        m_wa = r_a;
                        m_wd = {carry_r, rv[3:1]};
                        c_nxt = rv[0];
                     end
                     default: pe_nxt = 1'b0;
                  endcase
               end
            endcase
         end
         default: pe_nxt = 1'b0;
      endcase
   end

   // pin inputs: three stages, value follows once stages two and three agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 70'h0;
         s2_r <= 70'h0;
         s3_r <= 70'h0;
         sv_r <= 70'h0;
      end else begin
         s1_r <= {wake_in, hold_in, unlock_in, port_in};
         s2_r <= s1_r;
         s3_r <= s2_r;
         sv_r <= (s2_r & s3_r) | (sv_r & (s2_r | s3_r));
      end
   end

   always @(posedge pclk) begin
      if (do_ex && m_we)
         mem[m_wa] <= m_wd;
      if (do_ex && push)
         stk[sp_r] <= {carry_r, bank_r, pc_inc};
      if (do_ex && ir_we)
         ireg_r[lo] <= mv;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_r <= `TMD_PC_RST;
         pm_addr <= `TMD_PC_RST;
         bank_r <= `TMD_BANK_RST;
         sp_r <= 3'd0;
         carry_r <= 1'b0;
         skip_r <= 1'b0;
         halted <= 1'b0;
         osc_stop <= 1'b0;
         per_we <= 1'b0;
         per_kind <= 4'h0;
         per_addr <= 4'h0;
         per_data <= 8'h00;
         for (i = 0; i < 16; i = i + 1) begin
            plat_r[i] <= 4'h0;
         end
         for (i = 0; i < 4; i = i + 1) begin
            stat_r[i] <= 4'h0;
         end
      end else begin
         per_we <= do_ex & pe_nxt;
         if (do_ex && pe_nxt) begin
            per_kind <= pk_nxt;
            per_addr <= pa_nxt;
            per_data <= pd_nxt;
         end
         if (halted && wake_s)
            halted <= 1'b0;
         else if (do_ex && halt_nxt)
            halted <= 1'b1;
         if (osc_stop && hold_s)
            osc_stop <= 1'b0;
         else if (do_ex && ostp_nxt)
            osc_stop <= 1'b1;
         if (active) begin
            if (skip_r) begin
               skip_r <= 1'b0;
               pc_r <= pc_inc;
               pm_addr <= pc_inc;
            end else begin
               skip_r <= skip_nxt;
               pc_r <= pc_nxt;
               pm_addr <= pc_nxt;
               bank_r <= bank_nxt;
               carry_r <= c_nxt;
               if (push)
                  sp_r <= sp_r + 3'd1;
               else if (pop)
                  sp_r <= sp_r - 3'd1;
               if (st_we)
                  stat_r[st_idx] <= st_val;
               if (pl_we)
                  plat_r[pa_nxt] <= pl_val;
            end
         end
      end
   end

   // apb slave: zero wait states, read data captured in the setup cycle
   wire        setup = psel & ~penable;
   wire        acc   = psel & penable & pready;
   wire        hit_c = (paddr == `TMD_CTRL_OFF);
   wire        hit_s = (paddr == `TMD_STAT_OFF);
   wire [31:0] stat_w = {5'h00, sp_r, 1'b0, osc_stop, halted, carry_r, bank_r, 3'h0, pc_r};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= `TMD_CTRL_RST;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            pslverr <= ~(hit_c | hit_s);
            if (pwrite || !(hit_c || hit_s))
               prdata <= 32'h00000000;
            else
               prdata <= hit_c ? {31'h00000000, run_r} : stat_w;
         end
         if (acc && pwrite && hit_c)
            run_r <= pwdata[0];
      end
   end
endmodule

/* File: tb/tmd_core_props.sv */
// assertions on the decoder's fetch, halt and peripheral strobe ports
`timescale 1ns/1ps
module tmd_core_props (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pslverr,
   input logic [12:0] pm_addr,
   input logic [15:0] pm_data,
   input logic        per_we,
   input logic [3:0]  per_kind,
   input logic [3:0]  per_addr,
   input logic [7:0]  per_data,
   input logic        halted,
   input logic        osc_stop
);
   logic [15:0] pd_r;
   logic [12:0] pa_r;
   logic        ret;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // word and address executed at the previous edge
   always @(posedge pclk) begin
      pd_r <= pm_data;
      pa_r <= pm_addr;
   end
   assign ret = (pd_r[15:8] == 8'h00 && pd_r[7:4] inside {4'h8, 4'h9, 4'hA}) || pd_r[15:5] == 11'h7FE;
   chk_seq_fetch: assert property ($changed(pm_addr) && pd_r[15:14] != 2'b10 && !ret |->
      pm_addr == pa_r + 13'd1) else $error("pc did not advance by one");
   chk_jump_target: assert property ($changed(pm_addr) && pd_r[15:14] == 2'b10 && pm_addr != pa_r + 13'd1
      |-> pm_addr == pd_r[12:0]) else $error("jump target wrong");
   chk_halt_freeze: assert property (halted |=> $stable(pm_addr)) else $error("pc moved while halted");
   chk_osc_freeze: assert property (osc_stop |=> $stable(pm_addr)) else $error("pc moved while stopped");
   chk_halt_cause: assert property ($rose(halted) |-> pd_r[15:4] == 12'h004) else $error("halt without cause");
   chk_osc_cause: assert property ($rose(osc_stop) |-> pd_r == 16'h0050) else $error("stop without cause");
   chk_beep_data: assert property (per_we && per_kind == 4'h3 |-> pd_r == {12'h006, per_data[3:0]})
      else $error("beep strobe wrong");
   chk_ctrl_kinds: assert property (per_we && per_kind inside {4'h1, 4'h2, 4'h4, 4'h5} |-> pd_r[15:8] == 8'h00
      && pd_r[3:0] == per_data[3:0] && pd_r[7:4] == (per_kind == 4'h4 ? 4'hB : per_kind == 4'h5 ? 4'hC : per_kind))
      else $error("control strobe wrong");
   chk_port_src: assert property (per_we && per_kind == 4'h9 |-> pd_r[15:10] == 6'b111011
      || pd_r[15:9] == 7'b0000001) else $error("port strobe without cause");
   chk_strobe_hold: assert property (!per_we |-> $stable({per_kind, per_addr, per_data}))
      else $error("strobe fields changed");
   cover property (per_we && per_kind == 4'h9);
   cover property ($rose(halted));
   cover property ($rose(osc_stop));
   cover property (psel && penable && pslverr);
endmodule
bind tmd_core tmd_core_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pslverr(pslverr), .pm_addr(pm_addr), .pm_data(pm_data), .per_we(per_we), .per_kind(per_kind),
   .per_addr(per_addr), .per_data(per_data), .halted(halted), .osc_stop(osc_stop));

/* File: tb/tmd_pmem.sv */
// program memory model: asynchronous rom of sixteen instruction words
`timescale 1ns/1ps
module tmd_pmem (
   input  logic [12:0] pm_addr,
   output logic [15:0] pm_data
);
   logic [15:0] mem [16];
   // words beyond the loaded area read as no operation
   assign pm_data = pm_addr < 13'd16 ? mem[pm_addr[3:0]] : 16'h0000;
endmodule

/* File: tb/tuner_mcu_instruction_decoder_tb.sv */
// self-checking bench for the tuner instruction decoder
`timescale 1ns/1ps
module tuner_mcu_instruction_decoder_tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        hold_in = 1'b0, wake_in = 1'b0, pready, pslverr, per_we, halted, osc_stop, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [12:0] pm_addr;
   logic [15:0] pm_data, q[$], e[$];
   logic [63:0] port_in = 64'h0;
   logic [3:0]  unlock_in = 4'h0, per_kind, per_addr;
   logic [7:0]  per_data;
   int          bad_count = 0, checks_done = 0, cyc = 0, pi = 0;

   tmd_core dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pm_addr(pm_addr), .pm_data(pm_data), .port_in(port_in), .unlock_in(unlock_in),
      .hold_in(hold_in), .wake_in(wake_in), .per_we(per_we), .per_kind(per_kind),
      .per_addr(per_addr), .per_data(per_data), .halted(halted), .osc_stop(osc_stop));
   tmd_pmem pm (.pm_addr(pm_addr), .pm_data(pm_data));

   initial begin
      forever #12.5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (per_we === 1'b1) q.push_back({per_kind, per_addr, per_data});
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so that a following call never drives psel twice in a step
      @(posedge pclk);
   endtask

   task automatic put_w(input logic [15:0] w);
      pm.mem[pi] = w;
      pi++;
   endtask

   // hold the cpu in reset while the program is swapped
   task automatic clr();
      presetn <= 1'b0;
      @(posedge pclk);
      foreach (pm.mem[i]) pm.mem[i] = 16'h0000;
      pi = 0;
   endtask

   // reset, start the cpu and let the loaded program run
   task automatic run(input int cycles);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      q.delete();
      apb(1'b1, 12'h000, 32'h1);
      repeat (cycles) @(posedge pclk);
   endtask

   task automatic cmpq(input logic [15:0] mk);
      chk(q.size(), e.size());
      for (int i = 0; i < q.size() && i < e.size(); i++) chk(q[i] & mk, e[i]);
      e.delete();
   endtask

   // result and skip of one arithmetic, compare or logic word
   function automatic logic [4:0] mdl(input int p, v, a, b, c);
      int   r;
      logic s;
      r = a;
      s = 1'b0;
      case (p)
         4, 5: begin
            r = a + b + (v > 1 ? c : 0);
            s = v[0] && r > 15;
         end
         6, 7: begin
            r = a - b - (v > 1 ? c : 0);
            s = v[0] && r < 0;
         end
         2: r = v < 2 ? a & b : a | b;
         3: r = a ^ b;
         1: s = v < 2 ? a == b : a >= b;
         default: s = v == 1 ? a != b : a < b;
      endcase
      return {s, r[3:0]};
   endfunction

   initial begin
      int          p, v, a, b, c, x, pv;
      logic        im;
      logic [4:0]  m;
      logic [7:0]  ck [5];
      logic [15:0] rt [2];
      ck = '{8'h11, 8'h22, 8'h36, 8'h4B, 8'h5C};
      rt = '{16'h0080, 16'h00A0};
      a = $urandom(94637);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      port_in <= {$urandom, $urandom};
      unlock_in <= 4'($urandom);
      @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0);
      for (p = 0; p < 8; p++) begin
         for (v = 0; v < 4; v++) begin
            if ((p == 0 && v % 2 == 0) || (p == 3 && v > 1)) continue;
            for (int k = 0; k < 3; k++) begin
               a = $urandom % 16;
               b = k == 0 ? a : $urandom % 16;
               c = $urandom % 2;
               im = p == 5 || p == 7 || (p < 4 && v % 2 == 1);
               clr();
               put_w(p > 5 ? 16'hE440 : 16'hE44F);
               put_w({12'hE45, 3'b000, c[0]});
               put_w(p > 5 ? 16'h6454 : 16'h4454);
               put_w(16'h0000);
               put_w({12'hE41, a[3:0]});
               put_w({12'hE42, b[3:0]});
               put_w({p[3:0], v[1:0], 2'b00, im ? 4'h1 : 4'h2, im ? b[3:0] : 4'h1});
               put_w(16'hEC11);
               put_w(16'hEC12);
               put_w(16'h8009);
               m = mdl(p, v, a, b, c);
               if (!m[4]) e.push_back({8'h91, 4'h0, m[3:0]});
               e.push_back({8'h92, 4'h0, m[3:0]});
               run(20);
               cmpq(16'hFFFF);
            end
         end
      end
      clr();
      foreach (ck[i]) begin
         a = $urandom % 16;
         put_w({8'h00, ck[i][3:0], a[3:0]});
         e.push_back({ck[i][7:4], 8'h00, a[3:0]});
      end
      put_w(16'h8005);
      run(15);
      cmpq(16'hF0FF);
      foreach (rt[i]) begin
         clr();
         put_w(16'hE417);
         put_w(16'hA005);
         put_w(16'hEC11);
         put_w(16'hEC12);
         put_w(16'h8004);
         put_w(rt[i]);
         if (i == 0) e.push_back(16'h9107);
         e.push_back(16'h9207);
         run(20);
         cmpq(16'hFFFF);
      end
      // shifts, same-row move, pin reads, unlock and bit tests, direct lcd write
      for (int k = 0; k < 4; k++) begin
         a = $urandom % 16;
         b = $urandom % 16;
         c = $urandom % 16;
         v = $urandom % 16;
         x = ((a & 1) << 3) | (a >> 2);
         pv = port_in[b * 4 +: 4];
         clr();
         put_w({12'hE43, a[3:0]});
         put_w(16'h00E3);
         put_w(16'h00E3);
         put_w(16'hE043);
         put_w({12'hE82, b[3:0]});
         put_w(16'hEC41);
         put_w(16'hEC22);
         put_w({12'h00D, c[3:0]});
         put_w(16'hEC43);
         put_w({8'hFC, b[3:0], v[3:0]});
         put_w(16'hEC44);
         put_w({12'hF03, v[3:0]});
         put_w(16'hEC45);
         put_w(16'hC035);
         put_w(16'h800E);
         e.push_back({8'h91, x[7:0]});
         e.push_back({8'h92, pv[7:0]});
         if ((unlock_in & c) != 0) e.push_back({8'h93, x[7:0]});
         if ((pv & v) != v) e.push_back({8'h94, x[7:0]});
         if ((x & v) != v) e.push_back({8'h95, x[7:0]});
         e.push_back({8'hA5, x[7:0]});
         run(20);
         cmpq(16'hFFFF);
      end
      clr();
      put_w(16'hE415);
      put_w(16'h0043);
      put_w(16'hEC11);
      put_w(16'h0050);
      put_w(16'hEC13);
      put_w(16'h8005);
      run(20);
      chk({halted, osc_stop, pm_addr}, {2'b10, 13'd2});
      wake_in <= 1'b1;
      repeat (20) @(posedge pclk);
      wake_in <= 1'b0;
      chk({halted, osc_stop, pm_addr}, {2'b01, 13'd4});
      hold_in <= 1'b1;
      repeat (20) @(posedge pclk);
      chk(osc_stop, 32'h0);
      q = q.find(x) with (x[15:12] == 4'h9);
      e = '{16'h9105, 16'h9305};
      cmpq(16'hFFFF);
      wrap_up();
   end
endmodule
